// ### rtl/bkmon_pkg.sv
// Package: register map, field layout and timing constants of the buck monitor
package bkmon_pkg;

  // -------------------------------------------------------------------------
  // Register offsets (byte addresses)
  // -------------------------------------------------------------------------
  localparam logic [7:0] REG_CTRL1   = 8'h00;
  localparam logic [7:0] REG_CTRL2   = 8'h04;
  localparam logic [7:0] REG_CTRL3   = 8'h08;
  localparam logic [7:0] REG_MASK    = 8'h0C;
  localparam logic [7:0] REG_FLAG    = 8'h10;
  localparam logic [7:0] REG_STATUS  = 8'h14;

  // -------------------------------------------------------------------------
  // Per-converter control register fields
  // -------------------------------------------------------------------------
  localparam int CT_CODE_LSB   = 0;   // Target code [7:0]
  localparam int CT_EN         = 8;   // Host enable
  localparam int CT_MODE_LSB   = 9;   // Power mode [10:9]
  localparam int CT_DIS_OFF    = 11;  // Discharge disable
  localparam int CT_FALL_RAMP  = 12;  // Falling ramp enable (buck1)
  localparam int CT_SEQ_LSB    = 16;  // Sequencer slot config [23:16]
  localparam int CT_SEQ_IN     = 16;  // Bit 16: takes part in sequence
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // -------------------------------------------------------------------------
  // Flag / mask / status layout: bits 0..2 brownout, 3..5 overvoltage,
  // 6..8 current limit (status only), converter index 0=buck1
  // -------------------------------------------------------------------------
  localparam int F_UV = 0;
  localparam int F_OV = 3;
  localparam int F_IL = 6;
  localparam logic [5:0] MASK_RESET = 6'h00;

  // Power mode codes
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_FORCE  = 2'h2;

  // -------------------------------------------------------------------------
  // Timing: soft-start slew 17 mV/us, code step 12.5 mV, base 600 mV
  // -------------------------------------------------------------------------
  localparam int CLK_MHZ        = 200;
  localparam int SLEW_UV_PER_US = 17000;
  localparam int STEP_UV        = 12500;
  localparam int BASE_UV        = 600000;
  localparam int CYC_PER_CODE   = (STEP_UV * CLK_MHZ + SLEW_UV_PER_US - 1) / SLEW_UV_PER_US;
  localparam int CYC_BASE       = (BASE_UV * CLK_MHZ + SLEW_UV_PER_US - 1) / SLEW_UV_PER_US;
  localparam int MAX_CODE       = 254;  // 0.600 V + 254*12.5 mV = 3.775 V, below 3.78 V
  localparam int SS_W           = 17;

endpackage : bkmon_pkg

// ### rtl/bkmon_top.sv
// Digital control and supervision for three step-down converters
//
// Overview of operation
// - Each converter sets its overvoltage flag when output exceeds threshold.
// - Unmasked buck1 overvoltage requests power-down and asserts interrupt_request_n.
// - Buck1 falling ramp enabled: overvoltage suppressed until the down ramp ends.
// - Falling ramp disabled: lowering target raises overvoltage immediately.
// - Each brownout, overvoltage, current-limit condition has a live status bit.
// - Buck1 enabled by sequencer or host register write.
// - Per-converter sequencer config selects participation, master and slot; only participation (bit 16) is used here.
// - Two-bit power-mode field selects normal or low-power operation.
// - Configured converters go low-power during deep sleep, return afterwards.
// - Host command can force low-power regardless of sleep state.
// - Buck2/3 set brownout flag; unmasked brownout requests power-down.
// - Buck2/3 brownout blanked until soft-start period ends.
// - Buck2/3 overvoltage blanked until soft-start period ends.
// - Raising a running buck2/3 target steps straight to new code.
// - Such a step raises undervoltage; unmasked it requests power-down.
// - Masked faults still set flags; mask only gates power-down and interrupt.
// - Buck2/3 discharge enabled after reset; disable bit turns it off.
// - Discharge enabled: path on while converter off, off while on.
// - Buck2/3 soft-start ramps at 17 mV/us; time equals target over rate.
// - Buck2 code maps from 0.600 V in 12.5 mV steps, max 3.78 V.
// - Buck1 sets brownout flag; unmasked brownout requests power-down.
// - Buck1 brownout held off until soft-start completes.
// - Buck1 brownout held off while ramping up to a raised target.
// - Buck1 discharge path connects when switched off with discharge enabled.
//
// Our own choices: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps

module bkmon_top
  import bkmon_pkg::*;
#(
  parameter int NUM_BUCK = 3,    // Converters served; ports and logic assume three
  parameter int SS_CNT_W = SS_W  // Soft-start counter width
)
(
  input  wire logic        clk,              // 200 MHz system clock
  input  wire logic        reset,            // Synchronous, active high
  input  wire logic [31:0] haddr,            // AHB address
  input  wire logic [1:0]  htrans,           // AHB transfer type
  input  wire logic        hwrite,           // AHB write
  input  wire logic [2:0]  hsize,            // AHB size
  input  wire logic [31:0] hwdata,           // AHB write data
  input  wire logic        hsel,             // AHB select
  input  wire logic        hready,           // AHB bus ready
  output logic      [31:0] hrdata,           // AHB read data
  output logic             hreadyout,        // AHB slave ready
  output logic             hresp,            // AHB response (OKAY)
  input  wire logic [2:0]  seq_enable,       // Sequencer enable per converter
  input  wire logic        deep_sleep_state, // Chip in deep sleep
  input  wire logic [2:0]  cmp_brownout,     // Raw brownout comparators
  input  wire logic [2:0]  cmp_overvoltage,  // Raw overvoltage comparators
  input  wire logic [2:0]  cmp_current_limit,// Raw current-limit comparators
  input  wire logic        buck1_ramp_busy,  // Buck1 analog ramp in progress
  output logic      [2:0]  buck_on,          // Converter enabled
  output logic      [2:0]  low_power_operation, // Converter in low power
  output logic      [2:0]  discharge_on,     // 100 ohm discharge path connected
  output logic      [23:0] target_code,      // Applied target codes, buck1 in [7:0]
  output logic             power_down_request, // To sequencer
  output logic             interrupt_request_n // Active-low interrupt
);
  import bkmon_pkg::*;

  // -------------------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------------------
  // Fault vectors and the register map are laid out for three converters
  if (NUM_BUCK != 3) begin : g_bad_count
    $error("bkmon_top serves exactly three converters");
  end
  // The counter must hold the longest window, at the top code, without wrapping
  if (SS_CNT_W < 1 || SS_CNT_W > 30 || (2 ** SS_CNT_W) <= CYC_BASE + MAX_CODE * CYC_PER_CODE) begin : g_bad_width
    $error("soft-start counter too narrow");
  end

  // -------------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------------
  typedef enum logic [1:0] {
    BK_IDLE = 2'b01,
    BK_DATA = 2'b10
  } bkmon_bus_e;

  typedef struct packed {
    bkmon_bus_e                  bus;
    logic                        wr;
    logic [7:0]                  addr;
    logic [2:0][31:0]            ctrl;
    logic [5:0]                  mask;
    logic [5:0]                  flag;
    logic [2:0]                  on;
    logic [2:0][SS_CNT_W-1:0]    ss_cnt;
    logic [7:0]                  b1_prev_code;
    logic                        b1_hold_ov;
    logic                        b1_hold_uv;
    logic [31:0]                 rdata;
    logic                        pdr;
    logic                        irq;
    logic [2:0]                  lp;
    logic [2:0]                  dis;
  } bkmon_state_s;

  bkmon_state_s st;
  bkmon_state_s next_st;

  // Soft-start length in cycles for a target code at 17 mV/us
  function automatic logic [SS_CNT_W-1:0] bkmon_ss_cycles(input logic [7:0] code);
    bkmon_ss_cycles = SS_CNT_W'(CYC_BASE) + SS_CNT_W'(code) * SS_CNT_W'(CYC_PER_CODE);
  endfunction : bkmon_ss_cycles

  // Applied code, clipped so the output never passes 3.78 V
  function automatic logic [7:0] bkmon_clip(input logic [7:0] code);
    bkmon_clip = (code > 8'(MAX_CODE)) ? 8'(MAX_CODE) : code;
  endfunction : bkmon_clip

  logic [2:0] blanked;
  logic [2:0] en_now;
  logic [2:0] uv_live;
  logic [2:0] ov_live;
  logic [5:0] fault;
  logic       b1_ov_hide;
  logic       b1_uv_hide;

  // -------------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------------
  always_comb begin
    logic [7:0]  c;
    logic [31:0] rd;
    next_st = st;
    c       = 8'h00;
    rd      = 32'h0000_0000;

    for (int i = 0; i < 3; i++) begin
      en_now[i] = st.ctrl[i][CT_EN] | (st.ctrl[i][CT_SEQ_IN] & seq_enable[i]);
    end
    next_st.on = en_now;

    // Soft-start blanking for buck2/3, restarted at each enable
    for (int i = 1; i < 3; i++) begin
      c = bkmon_clip(st.ctrl[i][7:0]);
      if (en_now[i] && !st.on[i]) begin
        next_st.ss_cnt[i] = bkmon_ss_cycles(c);
      end else if (!en_now[i]) begin
        next_st.ss_cnt[i] = '0;
      end else if (st.ss_cnt[i] != '0) begin
        next_st.ss_cnt[i] = st.ss_cnt[i] - SS_CNT_W'(1);
      end
    end
    next_st.ss_cnt[0] = '0;

    // Buck1 ramp hold: falling ramp hides overvoltage, rising hides brownout
    if (en_now[0] && !st.on[0]) begin
      next_st.b1_hold_uv = 1'b1;
    end else if (st.ctrl[0][7:0] > st.b1_prev_code) begin
      next_st.b1_hold_uv = 1'b1;
    end else if (!buck1_ramp_busy) begin
      next_st.b1_hold_uv = 1'b0;
    end
    if (st.ctrl[0][7:0] < st.b1_prev_code && st.ctrl[0][CT_FALL_RAMP]) begin
      next_st.b1_hold_ov = 1'b1;
    end else if (!buck1_ramp_busy) begin
      next_st.b1_hold_ov = 1'b0;
    end
    next_st.b1_prev_code = st.ctrl[0][7:0];

    blanked[0] = 1'b0;
    // First enabled cycle is blanked too, before the counter has loaded
    blanked[1] = en_now[1] && (!st.on[1] || st.ss_cnt[1] != '0);
    blanked[2] = en_now[2] && (!st.on[2] || st.ss_cnt[2] != '0);
    // Registered holds start a cycle after the code write; the compare covers that cycle
    b1_uv_hide = st.b1_hold_uv || (en_now[0] && !st.on[0]) || (st.ctrl[0][7:0] > st.b1_prev_code);
    b1_ov_hide = st.b1_hold_ov || (st.ctrl[0][CT_FALL_RAMP] && (st.ctrl[0][7:0] < st.b1_prev_code));
    uv_live = cmp_brownout & en_now & ~blanked & {2'b11, ~b1_uv_hide};
    ov_live = cmp_overvoltage & en_now & ~blanked & {2'b11, ~b1_ov_hide};
    fault   = {ov_live, uv_live};

    // Power mode and discharge
    for (int i = 0; i < 3; i++) begin
      next_st.lp[i] = (st.ctrl[i][CT_MODE_LSB +: 2] == MODE_FORCE) ||
                      (st.ctrl[i][CT_MODE_LSB +: 2] == MODE_SLEEP && deep_sleep_state);
      next_st.dis[i] = !st.ctrl[i][CT_DIS_OFF] && !en_now[i];
    end

    next_st.pdr = |(fault & ~st.mask);
    next_st.irq = |(fault & ~st.mask & 6'b001000);

    // Bus slave: address phase captured, data phase answered next cycle
    next_st.bus = BK_IDLE;
    case (st.bus)
      BK_IDLE, BK_DATA: begin
        if (hsel && hready && htrans[1]) begin
          next_st.bus  = BK_DATA;
          next_st.wr   = hwrite;
          next_st.addr = haddr[7:0];
        end
      end
      default: next_st.bus = BK_IDLE;
    endcase

    if (st.bus == BK_DATA && st.wr) begin
      case (st.addr)
        REG_CTRL1: next_st.ctrl[0] = hwdata;
        REG_CTRL2: next_st.ctrl[1] = hwdata;
        REG_CTRL3: next_st.ctrl[2] = hwdata;
        REG_MASK:  next_st.mask    = hwdata[5:0];
        REG_FLAG:  next_st.flag    = st.flag & ~hwdata[5:0]; // Write one to clear
        default: ;
      endcase
    end
    next_st.flag = next_st.flag | fault; // Set beats clear

    case (haddr[7:0])
      REG_CTRL1:  rd = st.ctrl[0];
      REG_CTRL2:  rd = st.ctrl[1];
      REG_CTRL3:  rd = st.ctrl[2];
      REG_MASK:   rd = {26'h0, st.mask};
      REG_FLAG:   rd = {26'h0, st.flag};
      REG_STATUS: rd = {23'h0, cmp_current_limit & en_now, ov_live, uv_live};
      default:    rd = 32'h0000_0000;
    endcase
    next_st.rdata = (hsel && hready && htrans[1] && !hwrite) ? rd : st.rdata;
  end

  // -------------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      next_st_reset_block: begin
        st.bus          <= BK_IDLE;
        st.wr           <= 1'b0;
        st.addr         <= 8'h00;
        st.ctrl         <= {3{CTRL_RESET}};
        st.mask         <= MASK_RESET;
        st.flag         <= 6'h00;
        st.on           <= 3'h0;
        st.ss_cnt       <= '0;
        st.b1_prev_code <= 8'h00;
        st.b1_hold_ov   <= 1'b0;
        st.b1_hold_uv   <= 1'b0;
        st.rdata        <= 32'h0000_0000;
        st.pdr          <= 1'b0;
        st.irq          <= 1'b0;
        st.lp           <= 3'h0;
        st.dis          <= 3'h7; // Discharge enabled from reset
      end
    end else begin
      st <= next_st;
    end
  end

  assign hrdata              = st.rdata;
  assign hreadyout           = 1'b1;
  assign hresp               = 1'b0;
  assign buck_on             = st.on;
  assign low_power_operation = st.lp;
  assign discharge_on        = st.dis;
  assign target_code         = {bkmon_clip(st.ctrl[2][7:0]), bkmon_clip(st.ctrl[1][7:0]),
                                st.ctrl[0][7:0]};
  assign power_down_request  = st.pdr;
  assign interrupt_request_n = ~st.irq;

  // -------------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------------
  a_pdr_cause: assert property (@(posedge clk) disable iff (reset)
    (|(fault & ~st.mask)) |=> power_down_request)
    else $error("fault did not request power-down");
  a_masked_flag: assert property (@(posedge clk) disable iff (reset)
    (fault[F_OV] && st.mask[F_OV]) |=> (st.flag[F_OV] && !st.irq))
    else $error("masked fault mishandled");
  a_irq_b1ov: assert property (@(posedge clk) disable iff (reset)
    (ov_live[0] && !st.mask[F_OV]) |=> !interrupt_request_n)
    else $error("buck1 ov did not interrupt");
  a_flag_sticky: assert property (@(posedge clk) disable iff (reset)
    (st.flag[0] && !(st.bus == BK_DATA && st.wr && st.addr == REG_FLAG)) |=> st.flag[0])
    else $error("flag lost");
  a_ss_blank: assert property (@(posedge clk) disable iff (reset)
    (en_now[1] && !st.on[1]) |=> (!uv_live[1] && !ov_live[1]))
    else $error("buck2 not blanked");
  a_ss_len: assert property (@(posedge clk) disable iff (reset)
    (en_now[2] && !st.on[2]) |=> (st.ss_cnt[2] == bkmon_ss_cycles(bkmon_clip(st.ctrl[2][7:0]))))
    else $error("bad ss");
  a_disch_off: assert property (@(posedge clk) disable iff (reset)
    en_now[1] |=> !discharge_on[1])
    else $error("discharge on while enabled");
  a_lp_force: assert property (@(posedge clk) disable iff (reset)
    (st.ctrl[0][CT_MODE_LSB +: 2] == MODE_FORCE) |=> low_power_operation[0])
    else $error("force lp ignored");

  // -------------------------------------------------------------------------
  // Assertions: buck1 ramp holds, soft-start window and outputs
  // -------------------------------------------------------------------------
  // The write cycle itself must already be hidden, not only the ramp after it
  a_b1_ov_hide: assert property (@(posedge clk) disable iff (reset)
    (st.ctrl[0][CT_FALL_RAMP] && (st.ctrl[0][7:0] < st.b1_prev_code)) |-> !ov_live[0])
    else $error("buck1 overvoltage seen during falling ramp");
  a_b1_ov_plain: assert property (@(posedge clk) disable iff (reset)
    (!st.ctrl[0][CT_FALL_RAMP] && !st.b1_hold_ov && cmp_overvoltage[0] && en_now[0]) |-> ov_live[0])
    else $error("buck1 overvoltage hidden without falling ramp");
  a_b1_uv_start: assert property (@(posedge clk) disable iff (reset)
    (en_now[0] && !st.on[0]) |-> !uv_live[0])
    else $error("buck1 brownout seen at enable");
  a_b1_uv_rise: assert property (@(posedge clk) disable iff (reset)
    (st.ctrl[0][7:0] > st.b1_prev_code) |-> !uv_live[0])
    else $error("buck1 brownout seen during rising code");
  // Blanking must end as well, or a stuck counter would hide every fault
  a_ss_expire: assert property (@(posedge clk) disable iff (reset)
    (en_now[1] && st.on[1] && (st.ss_cnt[1] == '0) && cmp_brownout[1]) |-> uv_live[1])
    else $error("buck2 brownout still blanked");
  a_ov_blank3: assert property (@(posedge clk) disable iff (reset)
    (en_now[2] && (st.ss_cnt[2] != '0)) |-> !ov_live[2])
    else $error("buck3 overvoltage not blanked");
  a_flag_set: assert property (@(posedge clk) disable iff (reset)
    (|fault) |=> ((st.flag & $past(fault)) == $past(fault)))
    else $error("fault did not set its flag");
  a_disch_idle: assert property (@(posedge clk) disable iff (reset)
    (!en_now[2] && !st.ctrl[2][CT_DIS_OFF]) |=> discharge_on[2])
    else $error("discharge off while converter off");
  a_lp_sleep: assert property (@(posedge clk) disable iff (reset)
    ((st.ctrl[1][CT_MODE_LSB +: 2] == MODE_SLEEP) && deep_sleep_state) |=> low_power_operation[1])
    else $error("deep sleep did not select low power");
  a_on_follow: assert property (@(posedge clk) disable iff (reset)
    en_now[0] |=> buck_on[0])
    else $error("buck1 enable not applied");

  // -------------------------------------------------------------------------
  // Cover points
  // -------------------------------------------------------------------------
  c_pdr: cover property (@(posedge clk) power_down_request);
  c_irq: cover property (@(posedge clk) !interrupt_request_n);
  c_ss_end: cover property (@(posedge clk) $fell(blanked[1]));
  c_b1_ov_hide: cover property (@(posedge clk) b1_ov_hide && cmp_overvoltage[0]);
  c_lp_sleep: cover property (@(posedge clk) low_power_operation[1] && deep_sleep_state);

endmodule : bkmon_top

// ### tb/bkmon_seq_model.sv
// Power sequencer partner model driving the per-converter sequencer enables
`timescale 1ns/10ps

module bkmon_seq_model (
  input  wire logic       clk,        // System clock
  input  wire logic       reset,      // Synchronous, active high
  input  wire logic [2:0] seq_req,    // Slots the bench wants powered
  input  wire logic       pdr,        // Power-down request from the monitor
  output logic      [2:0] seq_enable  // Enables into the monitor
);
  // ---------------------------------------------------------------------------
  // Slot enables
  // ---------------------------------------------------------------------------
  // A power-down request drops every slot, as a real sequencer would
  always_ff @(posedge clk) begin
    if (reset || pdr) begin
      seq_enable <= 3'h0;
    end else begin
      seq_enable <= seq_req;
    end
  end
endmodule : bkmon_seq_model

// ### tb/bkmon_tb_top.sv
// Self-checking testbench for the buck monitor over AHB-Lite
`timescale 1ns/10ps

module bkmon_tb_top;
  import bkmon_pkg::*;
  logic clk, reset, hwrite, hsel, hready, hreadyout, hresp, deep_sleep_state, buck1_ramp_busy;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, seq_enable, seq_req, cmp_brownout, cmp_overvoltage, cmp_current_limit;
  logic [2:0]  buck_on, low_power_operation, discharge_on;
  logic [23:0] target_code;
  logic        power_down_request, interrupt_request_n;
  int          error_cnt, checks, blank;
  logic [2:0]  mtbl [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h7};
  localparam logic [4:0] LP_EXP = 5'b01100;

  assign hready = hreadyout;

  bkmon_top bkmon_top_inst (.clk(clk), .reset(reset), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .seq_enable(seq_enable), .deep_sleep_state(deep_sleep_state),
    .cmp_brownout(cmp_brownout), .cmp_overvoltage(cmp_overvoltage), .cmp_current_limit(cmp_current_limit),
    .buck1_ramp_busy(buck1_ramp_busy), .buck_on(buck_on), .low_power_operation(low_power_operation),
    .discharge_on(discharge_on), .target_code(target_code), .power_down_request(power_down_request),
    .interrupt_request_n(interrupt_request_n));

  bkmon_seq_model bkmon_seq_model_inst (.clk(clk), .reset(reset), .seq_req(seq_req),
    .pdr(power_down_request), .seq_enable(seq_enable));

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // Single word transfer; waits on hready in both phases
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {24'h0, a};
    hsize  <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : ahb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    ahb(1'b1, a, d, x);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] x;
    ahb(1'b0, a, 32'h0, x);
    chk(nm, x, e);
  endtask : rdc

  task automatic summarize();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : summarize

  // ---------------------------------------------------------------------------
  // Clock, reset and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  initial begin
    cyc(40000);
    error_cnt++;
    summarize();
  end

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  initial begin
    {reset, hsel, hwrite, deep_sleep_state, buck1_ramp_busy} = 5'h10;
    {haddr, hwdata, htrans, hsize} = '0;
    {seq_req, cmp_brownout, cmp_overvoltage, cmp_current_limit} = '0;
    cyc(10);
    reset <= 1'b0;
    cyc(2);
    chk("discharge at reset", 32'(discharge_on), 32'h7);
    chk("irq at reset", 32'(interrupt_request_n), 32'h1);
    for (int i = 0; i < 7; i++) rdc("register reset", 8'(4 * i), 32'h0);
    // Buck1 overvoltage with and without the falling ramp
    for (int f = 1; f >= 0; f--) begin
      buck1_ramp_busy <= 1'b1;
      wr(REG_CTRL1, 32'h140 | (f << 12));
      wr(REG_CTRL1, 32'h120 | (f << 12));
      cmp_overvoltage <= 3'h1;
      cyc(4);
      chk("pdr during ramp", 32'(power_down_request), 32'(1 - f));
      chk("irq during ramp", 32'(interrupt_request_n), 32'(f));
      buck1_ramp_busy <= 1'b0;
      cyc(4);
      chk("pdr after ramp", 32'(power_down_request), 32'h1);
      rdc("ov status", REG_STATUS, 32'h8);
      cmp_overvoltage <= 3'h0;
      cyc(3);
      rdc("flag latched", REG_FLAG, 32'h8);
      rdc("status live", REG_STATUS, 32'h0);
      wr(REG_FLAG, 32'h3F);
      rdc("flag cleared", REG_FLAG, 32'h0);
    end
    // Masked first before lowering without falling ramp
    wr(REG_MASK, 32'h8);
    wr(REG_CTRL1, 32'h140);
    wr(REG_CTRL1, 32'h120);
    cmp_overvoltage <= 3'h1;
    cyc(4);
    chk("masked pdr", 32'(power_down_request), 32'h0);
    chk("masked irq", 32'(interrupt_request_n), 32'h1);
    rdc("masked flag", REG_FLAG, 32'h8);
    cmp_overvoltage <= 3'h0;
    wr(REG_MASK, 32'h0);
    wr(REG_FLAG, 32'h3F);
    // Soft-start blanking: buck2 brownout, buck3 overvoltage
    for (int i = 1; i <= 2; i++) begin
      cmp_brownout    <= (i == 1) ? 3'h2 : 3'h0;
      cmp_overvoltage <= (i == 2) ? 3'h4 : 3'h0;
      blank = CYC_BASE + i * CYC_PER_CODE;
      wr(8'(4 * i), 32'h100 | i);
      cyc(blank - 60);
      chk("pdr blanked", 32'(power_down_request), 32'h0);
      cyc(120);
      chk("pdr after soft-start", 32'(power_down_request), 32'h1);
      cmp_brownout    <= 3'h0;
      cmp_overvoltage <= 3'h0;
      cyc(3);
      wr(REG_FLAG, 32'h3F);
    end
    // Step increase of running buck2
    wr(REG_MASK, 32'h2);
    wr(REG_CTRL2, 32'h1FF);
    cmp_brownout <= 3'h2;
    cyc(3);
    chk("buck2 code clipped", 32'(target_code[15:8]), 32'hFE);
    chk("buck3 code", 32'(target_code[23:16]), 32'h2);
    chk("step masked pdr", 32'(power_down_request), 32'h0);
    rdc("step flag", REG_FLAG, 32'h2);
    wr(REG_MASK, 32'h0);
    cyc(3);
    chk("step unmasked pdr", 32'(power_down_request), 32'h1);
    cmp_brownout <= 3'h0;
    cyc(3);
    wr(REG_FLAG, 32'h3F);
    // Power modes against deep sleep
    for (int k = 0; k < 5; k++) begin
      deep_sleep_state <= mtbl[k][0];
      wr(REG_CTRL2, 32'h1FF | (32'(mtbl[k][2:1]) << 9));
      cyc(3);
      chk("low power", 32'(low_power_operation[1]), 32'(LP_EXP[k]));
    end
    deep_sleep_state <= 1'b0;
    // Discharge path on buck3
    wr(REG_CTRL3, 32'h800);
    cyc(3);
    chk("discharge disabled", 32'(discharge_on[2]), 32'h0);
    wr(REG_CTRL3, 32'h0);
    cyc(3);
    chk("discharge when off", 32'(discharge_on[2]), 32'h1);
    // Buck1 under sequencer control
    wr(REG_CTRL1, 32'h10000);
    seq_req <= 3'h1;
    cyc(4);
    chk("seq enable", 32'({buck_on[0], discharge_on[0]}), 32'h2);
    seq_req <= 3'h0;
    cyc(4);
    chk("seq disable", 32'({buck_on[0], discharge_on[0]}), 32'h1);
    cmp_current_limit <= 3'h7;
    cyc(3);
    rdc("current limit status", REG_STATUS, 32'h80);
    rdc("unmapped read", 8'h18, 32'h0);
    summarize();
  end
endmodule : bkmon_tb_top
